// ### core/ring_10g_reconciler.v
/*
 Reconciler between a ring MAC byte stream and a 32-bit plus 4-control
 lane interface, with a byte FIFO on the transmit path.
 Assumes tx_clk and rx_clk are far slower than sys_clk (each phase at
 least four sys_clk cycles) so edges can be found by sampling.
*/
`timescale 1ns/100ps
`include "ring_consts.vh"

module byte_fifo #(
    parameter W = 9,
    parameter AW = 2
) (
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    // Fill side
    input wire [W-1:0] in_data,
    input wire in_valid,
    output reg in_ready,
    // Drain side
    output wire [W-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW:0] cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_reg];

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Ready is registered so it can leave the top level from a flop
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
            cnt_reg <= cnt_next;
            in_ready <= (cnt_next < DEPTH);
        end
    end
endmodule // byte_fifo

module ring_10g_reconciler #(
    parameter FIFO_AW = 2
) (
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    // MAC transmit side
    input wire [7:0] tx_byte,
    input wire tx_byte_last,
    input wire frame_send_request,
    input wire [15:0] tx_len,
    output wire tx_byte_ready,
    output reg tx_ready_notice,
    output reg tx_ready_change,
    // Transmit lanes
    input wire tx_clk,
    output reg [31:0] txd,
    output reg [3:0] txc,
    // Receive lanes
    input wire rx_clk,
    input wire [31:0] rxd,
    input wire [3:0] rxc,
    // MAC receive side
    output reg [7:0] rx_byte,
    output reg rx_byte_valid,
    output reg frame_receive_notice,
    output reg rx_frame_error,
    output reg [15:0] rx_len,
    // Link status
    input wire signal_fail,
    output reg link_ok,
    output reg link_state_notice
);
    // ----------------------------------------------------------
    // Sampling of the outside inputs
    // ----------------------------------------------------------
    reg [2:0] txk_s;
    reg [2:0] rxk_s;
    reg [2:0] sf_s;
    reg [35:0] rxw_s1;
    reg [35:0] rxw_s2;
    reg sf_reg;
    wire tx_edge = ~txk_s[1] & txk_s[2];
    wire rx_edge = rxk_s[1] & ~rxk_s[2];

    // Data stays put for half a link period, so two stages suffice
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            txk_s <= 3'h0;
            rxk_s <= 3'h0;
            sf_s <= 3'h0;
            rxw_s1 <= 36'h0;
            rxw_s2 <= 36'h0;
        end else begin
            txk_s <= {txk_s[1:0], tx_clk};
            rxk_s <= {rxk_s[1:0], rx_clk};
            sf_s <= {sf_s[1:0], signal_fail};
            rxw_s1 <= {rxc, rxd};
            rxw_s2 <= rxw_s1;
        end
    end

    // ----------------------------------------------------------
    // Transmit FIFO
    // ----------------------------------------------------------
    wire [8:0] fifo_out;
    wire fifo_valid;
    wire fifo_pop;
    // The length argument is deliberately left unread
    byte_fifo #(.W(9), .AW(FIFO_AW)) tx_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_data({tx_byte_last, tx_byte}),
        .in_valid(frame_send_request),
        .in_ready(tx_byte_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // ----------------------------------------------------------
    // Transmit framing
    // ----------------------------------------------------------
    localparam [3:0] TS_IDLE = 4'b0001;
    localparam [3:0] TS_PRE = 4'b0010;
    localparam [3:0] TS_DATA = 4'b0100;
    localparam [3:0] TS_GAP = 4'b1000;
    reg [3:0] ts_reg;
    reg [31:0] asm_reg;
    reg [2:0] asm_cnt_reg;
    reg asm_last_reg;
    reg [4:0] gap_reg;
    reg [31:0] dw;
    reg [3:0] dc;
    integer i;

    assign fifo_pop = fifo_valid & ~asm_last_reg & (asm_cnt_reg != 3'h4) &
        (ts_reg[1] | ts_reg[2]) & ~tx_edge;

    // Lane i carries data, then terminate, idles after it; a starved
    // lane gets an error character rather than stale data
    always @* begin
        dw = 32'h0;
        dc = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if (i < asm_cnt_reg) begin
                dw[i*8 +: 8] = asm_reg[i*8 +: 8];
                dc[i] = 1'b0;
            end else if (asm_last_reg && i == asm_cnt_reg) begin
                dw[i*8 +: 8] = `RM_TERM;
                dc[i] = 1'b1;
            end else if (asm_last_reg) begin
                dw[i*8 +: 8] = `RM_IDLE;
                dc[i] = 1'b1;
            end else begin
                dw[i*8 +: 8] = `RM_ERROR;
                dc[i] = 1'b1;
            end
        end
    end

    // Words change on the falling link edge so they are stable at rising
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ts_reg <= TS_IDLE;
            txd <= {4{`RM_IDLE}};
            txc <= 4'hF;
            asm_reg <= 32'h0;
            asm_cnt_reg <= 3'h0;
            asm_last_reg <= 1'b0;
            gap_reg <= 5'h0;
        end else begin
            if (fifo_pop) begin
                asm_reg[asm_cnt_reg[1:0]*8 +: 8] <= fifo_out[7:0];
                asm_cnt_reg <= asm_cnt_reg + 3'h1;
                asm_last_reg <= fifo_out[8];
            end
            if (tx_edge) begin
                case (ts_reg)
                    TS_IDLE: begin
                        if (fifo_valid) begin
                            txd <= {{3{`RM_PREAMBLE}}, `RM_START};
                            txc <= 4'h1;
                            ts_reg <= TS_PRE;
                        end else begin
                            txd <= {4{`RM_IDLE}};
                            txc <= 4'hF;
                        end
                    end
                    TS_PRE: begin
                        txd <= {`RM_SFD, {3{`RM_PREAMBLE}}};
                        txc <= 4'h0;
                        ts_reg <= TS_DATA;
                    end
                    TS_DATA: begin
                        txd <= dw;
                        txc <= dc;
                        asm_cnt_reg <= 3'h0;
                        if (asm_last_reg && asm_cnt_reg != 3'h4) begin
                            asm_last_reg <= 1'b0;
                            gap_reg <= 5'h4 - {2'h0, asm_cnt_reg};
                            ts_reg <= TS_GAP;
                        end
                    end
                    TS_GAP: begin
                        txd <= {4{`RM_IDLE}};
                        txc <= 4'hF;
                        gap_reg <= gap_reg + 5'h4;
                        if (gap_reg >= `RM_MIN_GAP) begin
                            ts_reg <= TS_IDLE;
                        end
                    end
                    default: ts_reg <= TS_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------
    // Transmit ready status
    // ----------------------------------------------------------
    wire ready_next = tx_ready_notice ?
        ~(frame_send_request & tx_byte_ready) :
        (ts_reg == TS_IDLE) & ~fifo_valid;

    // The MAC holds off its next frame while ready is low
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_ready_notice <= 1'b1;
            tx_ready_change <= 1'b0;
        end else begin
            tx_ready_notice <= ready_next;
            tx_ready_change <= ready_next ^ tx_ready_notice;
        end
    end

    // ----------------------------------------------------------
    // Receive deframing
    // ----------------------------------------------------------
    localparam [2:0] RS_IDLE = 3'b001;
    localparam [2:0] RS_PRE = 3'b010;
    localparam [2:0] RS_DATA = 3'b100;
    reg [2:0] rs_reg;
    reg [31:0] ub_data_reg;
    reg [3:0] ub_vld_reg;
    reg ub_end_reg;
    reg ub_err_reg;
    reg [1:0] fault_reg;
    reg [7:0] quiet_reg;
    reg [3:0] rmask;
    reg rend;
    reg rerr;
    reg [31:0] rdata;
    integer j;
    wire [31:0] rw = rxw_s2[31:0];
    wire [3:0] rc = rxw_s2[35:32];
    wire seq_col = rc == 4'h1 && rw[7:0] == `RM_SEQ;

    // Lanes up to the terminate are frame bytes; other controls are errors
    always @* begin
        rmask = 4'h0;
        rend = 1'b0;
        rerr = 1'b0;
        rdata = rw;
        for (j = 0; j < 4; j = j + 1) begin
            if (!rend) begin
                if (!rc[j]) begin
                    rmask[j] = 1'b1;
                end else if (rw[j*8 +: 8] == `RM_TERM) begin
                    rend = 1'b1;
                end else begin
                    rmask[j] = 1'b1;
                    rdata[j*8 +: 8] = `RM_ERROR;
                    rerr = 1'b1;
                end
            end
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rs_reg <= RS_IDLE;
            ub_data_reg <= 32'h0;
            ub_vld_reg <= 4'h0;
            ub_end_reg <= 1'b0;
            ub_err_reg <= 1'b0;
            rx_byte <= 8'h0;
            rx_byte_valid <= 1'b0;
            frame_receive_notice <= 1'b0;
            rx_frame_error <= 1'b0;
            rx_len <= 16'h0;
            fault_reg <= 2'h0;
            quiet_reg <= 8'h0;
        end else begin
            rx_byte <= ub_data_reg[7:0];
            rx_byte_valid <= ub_vld_reg[0];
            ub_data_reg <= {8'h0, ub_data_reg[31:8]};
            ub_vld_reg <= {1'b0, ub_vld_reg[3:1]};
            frame_receive_notice <= 1'b0;
            rx_len <= 16'h0;
            if (ub_end_reg && ub_vld_reg == 4'h0) begin
                frame_receive_notice <= 1'b1;
                rx_frame_error <= ub_err_reg;
                ub_end_reg <= 1'b0;
                ub_err_reg <= 1'b0;
            end
            if (rx_edge) begin
                case (rs_reg)
                    RS_IDLE: begin
                        // Idles and ordered sets deliver nothing
                        if (rc[0] && rw[7:0] == `RM_START) begin
                            rs_reg <= RS_PRE;
                        end
                    end
                    RS_PRE: rs_reg <= RS_DATA;
                    RS_DATA: begin
                        ub_data_reg <= rdata;
                        ub_vld_reg <= rmask;
                        ub_err_reg <= ub_err_reg | rerr;
                        if (rend) begin
                            ub_end_reg <= 1'b1;
                            rs_reg <= RS_IDLE;
                        end
                    end
                    default: rs_reg <= RS_IDLE;
                endcase
                // Fault clears after a quiet stretch of columns
                if (seq_col && rw[31:24] == `RM_LOCAL_FAULT) begin
                    fault_reg <= 2'h1;
                    quiet_reg <= 8'h0;
                end else if (seq_col && rw[31:24] == `RM_REMOTE_FAULT) begin
                    fault_reg <= 2'h2;
                    quiet_reg <= 8'h0;
                end else if (quiet_reg == `RM_FAULT_QUIET - 8'h1) begin
                    fault_reg <= 2'h0;
                end else begin
                    quiet_reg <= quiet_reg + 8'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------
    // Link status
    // ----------------------------------------------------------
    reg [1:0] fault_seen_reg;
    wire sf_next = (sf_s[1] == sf_s[2]) ? sf_s[2] : sf_reg;

    // Status is a single bit: there is no degrade value to report
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sf_reg <= 1'b0;
            fault_seen_reg <= 2'h0;
            link_ok <= 1'b0;
            link_state_notice <= 1'b0;
        end else begin
            sf_reg <= sf_next;
            fault_seen_reg <= fault_reg;
            link_ok <= (fault_reg == 2'h0) & ~sf_next;
            link_state_notice <= (fault_seen_reg != fault_reg) |
                (sf_next != sf_reg);
        end
    end
endmodule // ring_10g_reconciler

// ### core/ring_consts.vh
/*
 Constants for the ring 10G reconciler: control characters, preamble,
 gap length and fault timing. Included by the reconciler design file.
*/
`ifndef RING_CONSTS_VH
`define RING_CONSTS_VH
// ----------------------------------------------------------
// Control characters
// ----------------------------------------------------------
`define RM_IDLE 8'h07
`define RM_START 8'hFB
`define RM_TERM 8'hFD
`define RM_ERROR 8'hFE
`define RM_SEQ 8'h9C
// ----------------------------------------------------------
// Preamble bytes
// ----------------------------------------------------------
`define RM_PREAMBLE 8'h55
`define RM_SFD 8'hD5
// ----------------------------------------------------------
// Fault codes in lane 3 of a sequence ordered set
// ----------------------------------------------------------
`define RM_LOCAL_FAULT 8'h01
`define RM_REMOTE_FAULT 8'h02
// ----------------------------------------------------------
// Timing, in bytes and columns
// ----------------------------------------------------------
`define RM_MIN_GAP 5'h0C
`define RM_FAULT_QUIET 8'h80
`endif

// ### dv/phy_lane_model.sv
/* Far-side lane partner: free running link clocks, receive words from a queue,
   transmit words recorded. Assumes the bench fills rx_d and rx_c. */
`timescale 1ns/100ps
module phy_lane_model (
    // Link clocks
    output logic tx_clk,
    output logic rx_clk,
    // Lanes
    input wire [31:0] txd,
    input wire [3:0] txc,
    output logic [31:0] rxd,
    output logic [3:0] rxc
);
    logic [31:0] rx_d[$];
    logic [3:0] rx_c[$];
    logic [31:0] tx_d[$];
    logic [3:0] tx_c[$];
    // Offset link clock phases; each link period is 16 sys_clk periods, so edges do not drift against sys_clk
    initial begin
        tx_clk = 1'b0;
        forever #80 tx_clk = ~tx_clk;
    end
    initial begin
        rx_clk = 1'b0;
        #37;
        forever #80 rx_clk = ~rx_clk;
    end
    // Sampled mid word, long after the design updates on the falling edge
    always @(posedge tx_clk) begin
        tx_d.push_back(txd);
        tx_c.push_back(txc);
    end
    // Idle columns fill the time between queued words; one process owns the lanes
    initial begin
        rxd = 32'h07070707;
        rxc = 4'hF;
        forever begin
            @(negedge rx_clk);
            if (rx_d.size() > 0) begin
                rxd <= rx_d.pop_front();
                rxc <= rx_c.pop_front();
            end else begin
                rxd <= 32'h07070707;
                rxc <= 4'hF;
            end
        end
    end
endmodule // phy_lane_model

// ### dv/ring_10g_reconciler_properties.sv
/* Port checker for ring_10g_reconciler.
   Assumes one sys_clk domain with nrst as its asynchronous reset. */
`timescale 1ns/100ps
module ring_10g_reconciler_properties (
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    // Transmit side
    input wire frame_send_request,
    input wire tx_byte_ready,
    input wire tx_ready_notice,
    input wire tx_ready_change,
    input wire [31:0] txd,
    input wire [3:0] txc,
    // Receive and link
    input wire [15:0] rx_len,
    input wire signal_fail,
    input wire link_ok,
    input wire link_state_notice
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    rx_len_null_a: assert property (rx_len == 16'h0000)
        else $error("rx length not null");
    link_down_a: assert property (signal_fail [*4] |=> !link_ok)
        else $error("link ok while signal fail");
    link_notice_a: assert property ($changed(signal_fail) |-> ##[1:6] link_state_notice)
        else $error("no link notice");
    ready_pulse_a: assert property ($changed(tx_ready_notice) |-> tx_ready_change)
        else $error("no ready change pulse");
    pulse_cause_a: assert property (tx_ready_change |-> $changed(tx_ready_notice))
        else $error("spurious ready change");
    busy_on_take_a: assert property (frame_send_request && tx_byte_ready && tx_ready_notice |=> !tx_ready_notice)
        else $error("ready kept after take");
    idle_when_ready_a: assert property (tx_ready_notice |-> txd == 32'h07070707 && txc == 4'hF)
        else $error("lanes busy while ready");
    start_word_a: assert property (txc[0] && txd[7:0] == 8'hFB |-> txd[31:8] == 24'h555555 && txc[3:1] == 3'h0)
        else $error("bad start word");
    ctrl_char_a: assert property (txc[0] |-> txd[7:0] inside {8'h07, 8'hFB, 8'hFD, 8'hFE})
        else $error("bad lane 0 control");
endmodule // ring_10g_reconciler_properties

bind ring_10g_reconciler ring_10g_reconciler_properties u_ring_10g_reconciler_properties (
    .sys_clk(sys_clk), .nrst(nrst), .frame_send_request(frame_send_request),
    .tx_byte_ready(tx_byte_ready), .tx_ready_notice(tx_ready_notice),
    .tx_ready_change(tx_ready_change), .txd(txd), .txc(txc), .rx_len(rx_len),
    .signal_fail(signal_fail), .link_ok(link_ok), .link_state_notice(link_state_notice)
);

// ### dv/tb.sv
/* Self-checking bench for ring_10g_reconciler with the lane partner model.
   Assumes the design include path reaches core/. */
`timescale 1ns/100ps
module tb;
    logic sys_clk, nrst, tx_byte_last, frame_send_request, signal_fail, last_err, full_seen;
    logic [7:0] tx_byte, rx_byte;
    logic [15:0] tx_len, rx_len;
    logic [31:0] txd, rxd;
    logic [3:0] txc, rxc;
    logic tx_clk, rx_clk, tx_byte_ready, tx_ready_notice, tx_ready_change, rx_byte_valid;
    logic frame_receive_notice, rx_frame_error, link_ok, link_state_notice;
    int error_cnt = 0;
    int compares = 0;
    int chg_cnt = 0;
    int note_cnt = 0;
    int nfr = 0;
    logic [7:0] rx_got[$];
    logic [7:0] sb[$];
    logic sc[$];
    // Rows: frame length, length argument, lane of the terminate
    int rows[5][3] = '{'{1, 'hFFFF, 1}, '{2, 0, 2}, '{3, 7, 3}, '{4, 1, 0}, '{9, 'h1234, 1}};
    ring_10g_reconciler #(.FIFO_AW(2)) u_ring_10g_reconciler (
        .sys_clk(sys_clk), .nrst(nrst), .tx_byte(tx_byte), .tx_byte_last(tx_byte_last),
        .frame_send_request(frame_send_request), .tx_len(tx_len), .tx_byte_ready(tx_byte_ready),
        .tx_ready_notice(tx_ready_notice), .tx_ready_change(tx_ready_change), .tx_clk(tx_clk),
        .txd(txd), .txc(txc), .rx_clk(rx_clk), .rxd(rxd), .rxc(rxc), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid), .frame_receive_notice(frame_receive_notice),
        .rx_frame_error(rx_frame_error), .rx_len(rx_len), .signal_fail(signal_fail),
        .link_ok(link_ok), .link_state_notice(link_state_notice));
    phy_lane_model u_phy_lane_model (.tx_clk(tx_clk), .rx_clk(rx_clk), .txd(txd), .txc(txc),
        .rxd(rxd), .rxc(rxc));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (tx_ready_change === 1'b1) chg_cnt++;
        if (link_state_notice === 1'b1) note_cnt++;
        if (rx_byte_valid === 1'b1) rx_got.push_back(rx_byte);
        if (frame_receive_notice === 1'b1) last_err = rx_frame_error;
        if (frame_receive_notice === 1'b1) nfr++;
    end
    // ----
    // Tasks
    // ----
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_for(input string w, ref logic s, input logic v, input int lim);
        int k;
        for (k = 0; s !== v; k++) begin
            if (k > lim) check(w, v, s);
            if (k > lim) stop_test();
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic send(input int n, input int len_arg);
        int i;
        for (i = 0; i < n; i++) begin
            tx_byte = 8'h10 + 8'(i);
            tx_byte_last = (i == n - 1);
            tx_len = 16'(len_arg);
            frame_send_request = 1'b1;
            if (tx_byte_ready !== 1'b1) full_seen = 1'b1;
            wait_for("byte ready", tx_byte_ready, 1'b1, 400);
            @(posedge sys_clk);
            #1;
        end
        frame_send_request = 1'b0;
        tx_byte_last = 1'b0;
    endtask
    task automatic run_tx(input int n, input int len_arg, input int lane);
        int s, i, g;
        u_phy_lane_model.tx_d.delete();
        u_phy_lane_model.tx_c.delete();
        chg_cnt = 0;
        full_seen = 1'b0;
        s = 0;
        g = 0;
        send(n, len_arg);
        wait_for("ready low", tx_ready_notice, 1'b0, 5);
        wait_for("ready back", tx_ready_notice, 1'b1, 3000);
        repeat (2) @(posedge sys_clk);
        #1;
        check("ready changes", 2, chg_cnt);
        if (n > 4) check("fifo refused", 1, full_seen);
        sb.delete();
        sc.delete();
        foreach (u_phy_lane_model.tx_d[w]) for (i = 0; i < 4; i++) begin
            sb.push_back(u_phy_lane_model.tx_d[w][8*i +: 8]);
            sc.push_back(u_phy_lane_model.tx_c[w][i]);
        end
        for (i = sb.size() - 1; i >= 0; i--) if (sc[i] && sb[i] == 8'hFB) s = i;
        check("start", {1'b1, 8'hFB}, {sc[s], sb[s]});
        check("start lane", 0, s % 4);
        for (i = 1; i < 8; i++) check("preamble", {1'b0, (i == 7) ? 8'hD5 : 8'h55}, {sc[s+i], sb[s+i]});
        for (i = 0; i < n; i++) check("tx data", {1'b0, 8'h10 + 8'(i)}, {sc[s+8+i], sb[s+8+i]});
        check("terminate", {1'b1, 8'hFD}, {sc[s+8+n], sb[s+8+n]});
        check("term lane", lane, (s + 8 + n) % 4);
        for (i = s + 9 + n; i < sb.size() && sc[i] && sb[i] == 8'h07; i++) g++;
        check("gap", 1, g + 1 >= 12);
    endtask
    task automatic rxw(input logic [31:0] d, input logic [3:0] c);
        u_phy_lane_model.rx_d.push_back(d);
        u_phy_lane_model.rx_c.push_back(c);
    endtask
    task automatic rx_frame(input logic [7:0] b1, input logic [3:0] ctl, input logic err);
        int n, i;
        n = nfr;
        rx_got.delete();
        rxw(32'h555555FB, 4'h1);
        rxw(32'hD5555555, 4'h0);
        rxw({8'hA3, 8'hA2, b1, 8'hA0}, ctl);
        rxw(32'h07FDA5A4, 4'hC);
        for (i = 0; i < 400 && nfr == n; i++) @(posedge sys_clk);
        #1;
        check("rx frames", n + 1, nfr);
        if (nfr == n) stop_test();
        check("rx count", 6, rx_got.size());
        for (i = 0; i < 6; i++) check("rx byte", (i == 1) ? b1 : 8'hA0 + 8'(i), rx_got[i]);
        check("rx error", err, last_err);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        nrst = 1'b0;
        tx_byte = 8'h00;
        tx_byte_last = 1'b0;
        frame_send_request = 1'b0;
        tx_len = 16'h0000;
        signal_fail = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("reset txd", 32'h07070707, txd);
        check("reset ready", 1, tx_ready_notice);
        check("reset link", 0, link_ok);
        nrst = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        check("link up", 1, link_ok);
        foreach (rows[r]) run_tx(rows[r][0], rows[r][1], rows[r][2]);
        rx_frame(8'hA1, 4'h0, 1'b0);
        rx_frame(8'hFE, 4'h2, 1'b1);
        // Local then remote fault columns; each must drop and restore the link
        for (int f = 1; f < 3; f++) begin
            rx_got.delete();
            note_cnt = 0;
            rxw({8'(f), 16'h0000, 8'h9C}, 4'h1);
            wait_for("fault fail", link_ok, 1'b0, 200);
            check("seq hidden", 0, rx_got.size());
            wait_for("fault clear", link_ok, 1'b1, 3000);
            repeat (2) @(posedge sys_clk);
            #1;
            check("fault notices", 2, note_cnt);
        end
        note_cnt = 0;
        signal_fail = 1'b1;
        wait_for("fail down", link_ok, 1'b0, 10);
        signal_fail = 1'b0;
        wait_for("fail up", link_ok, 1'b1, 10);
        repeat (3) @(posedge sys_clk);
        #1;
        check("fail notices", 2, note_cnt);
        // Reset in mid frame must leave idle lanes and a clean next frame
        send(3, 0);
        nrst = 1'b0;
        #1;
        check("abort ready", 1, tx_ready_notice);
        check("abort idle", 32'h07070707, txd);
        repeat (2) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        run_tx(2, 0, 2);
        stop_test();
    end
    initial begin
        #400000;
        check("watchdog", 1, 0);
        stop_test();
    end
endmodule // tb
